// [fts_pkg.sv]
// package: register map, field layout, reset values and timing for the flash timer/status block
package fts_pkg;
    // register byte addresses
    localparam logic [7:0] FTS_ADDR_STROBE = 8'h03;
    localparam logic [7:0] FTS_ADDR_POWER  = 8'h04;
    // strobe register fields
    localparam int FTS_DUR_LSB   = 5;
    localparam int FTS_FAIL_BIT  = 4;
    localparam int FTS_RANGE_BIT = 3;
    localparam int FTS_TRIG_BIT  = 2;
    localparam int FTS_START_BIT = 1;
    localparam int FTS_BLANK_BIT = 0;
    // power register fields
    localparam int FTS_PG_BIT    = 7;
    localparam int FTS_TEMP_LSB  = 5;
    localparam int FTS_LIM_BIT   = 4;
    localparam int FTS_IND_LSB   = 0;
    // reset values
    localparam logic [2:0] FTS_DUR_RST   = 3'h6;
    localparam logic       FTS_BLANK_RST = 1'b1;
    localparam logic [3:0] FTS_IND_RST   = 4'h0;
    // operating mode codes and the temperature-field code read back during thermal shutdown
    localparam logic [1:0] FTS_MODE_OFF   = 2'h0;
    localparam logic [1:0] FTS_MODE_FLASH = 2'h2;
    localparam logic [1:0] FTS_TEMP_SHDN  = 2'h3;
    // timing: clock period in ps, durations in tenths of a millisecond
    localparam longint FTS_CLK_PS = 8000;
    localparam longint FTS_DUR0_US10 [8] = '{682, 1022, 1363, 1704, 2045, 3408, 5793, 8520};
    localparam longint FTS_DUR1_US10 [8] = '{53, 107, 160, 213, 266, 320, 373, 2077};
    // valley current limits in mA
    localparam logic [11:0] FTS_LIM_LO_MA   = 12'h4e2; // 1250
    localparam logic [11:0] FTS_LIM_HI_MA   = 12'h6d6; // 1750
    localparam logic [11:0] FTS_LIM_LOHC_MA = 12'h0fa; // 250
    localparam logic [11:0] FTS_LIM_HIHC_MA = 12'h1f4; // 500
    // register access bundle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fts_req_s;
endpackage

// [fts_regs.sv]
// flash safety timer, strobe control and status registers
`timescale 1ns/1ps
`default_nettype none
module fts_regs
    import fts_pkg::*;
#(
    parameter longint CLK_PS = FTS_CLK_PS
)(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire fts_req_s   req,             // register access, wr/rd one-cycle strobes
    output logic [7:0]      rdata,           // read data, registered
    input  wire logic [1:0] mode_code,       // operating mode from mode register
    input  wire logic       flash_sync_pin,  // flash trigger input
    input  wire logic       blank_pin,       // transmit blanking input
    input  wire logic       high_current_pin,
    input  wire logic       led_fault,       // open or short detected
    input  wire logic       power_good,      // converter within regulation
    input  wire logic [1:0] die_temp,        // 0..2 temperature band
    input  wire logic       thermal_shdn,    // thermal shutdown event
    input  wire logic       gpio_value,      // stored port value bit
    output logic            gpio_out,        // routed general-purpose port level
    output logic            strobe_active,   // flash strobe running
    output logic            current_reduced, // flash current cut to dc level
    output logic [11:0]     valley_limit_ma,
    output logic [3:0]      indicator_current_code
);
    // -------------------------------------------------------------
    // duration lookup
    // -------------------------------------------------------------
    // table entries are tenths of a millisecond, 1e8 ps each; rounding up
    // keeps a strobe from ever running shorter than the chosen limit
    function automatic logic [31:0] dur_cycles(input logic rng, input logic [2:0] code);
        longint us10;
        us10 = rng ? FTS_DUR1_US10[code] : FTS_DUR0_US10[code];
        return 32'(((us10 * 100000000) + CLK_PS - 1) / CLK_PS);
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic [2:0]  dur_r, dur_nxt;
    logic        range_r, range_nxt;
    logic        trig_r, trig_nxt;
    logic        blank_en_r, blank_en_nxt;
    logic        fail_r, fail_nxt;
    logic        tout_r, tout_nxt;
    logic        bevt_r, bevt_nxt;
    logic        shdn_r, shdn_nxt;
    logic        pgsel_r, pgsel_nxt;
    logic        lim_r, lim_nxt;
    logic        started_r, started_nxt;
    logic [3:0]  ind_r, ind_nxt;
    logic        act_r, act_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic        start_hold_r, start_hold_nxt;
    logic        sync_d_r;
    logic [7:0]  rdata_nxt;

    logic wr_strobe, rd_strobe, wr_power, rd_power;
    logic flash_mode, sync_rise, hw_start, sw_start, start, expire, level_end;

    // decode and start conditions
    assign wr_strobe  = req.wr && (req.addr == FTS_ADDR_STROBE);
    assign rd_strobe  = req.rd && (req.addr == FTS_ADDR_STROBE);
    assign wr_power   = req.wr && (req.addr == FTS_ADDR_POWER);
    assign rd_power   = req.rd && (req.addr == FTS_ADDR_POWER);
    assign flash_mode = (mode_code == FTS_MODE_FLASH);
    assign sync_rise  = flash_sync_pin && !sync_d_r;
    assign sw_start   = wr_strobe && req.wdata[FTS_START_BIT];
    // both trigger kinds start on the pin's rising edge, so a pin held high
    // past expiry cannot relaunch the strobe and defeat the safety timer
    assign hw_start   = flash_mode && sync_rise;
    assign start      = (sw_start || hw_start) && flash_mode;
    assign expire     = act_r && (cnt_r == 32'h1);
    assign level_end  = act_r && flash_mode && !trig_r && !flash_sync_pin && !sw_start
                        && !start_hold_r;

    // next-state computation
    always_comb
    begin
        dur_nxt      = dur_r;
        range_nxt    = range_r;
        trig_nxt     = trig_r;
        blank_en_nxt = blank_en_r;
        pgsel_nxt    = pgsel_r;
        lim_nxt      = lim_r;
        ind_nxt      = ind_r;
        started_nxt  = started_r || (mode_code != FTS_MODE_OFF);
        act_nxt      = act_r;
        cnt_nxt      = cnt_r;
        start_hold_nxt = start_hold_r && act_r;
        // event flags: set wins over read clear
        fail_nxt = led_fault || (fail_r && !rd_strobe);
        bevt_nxt = (blank_en_r && blank_pin) || (bevt_r && !rd_strobe);
        shdn_nxt = thermal_shdn || (shdn_r && !rd_power);
        tout_nxt = tout_r;
        if (wr_strobe)
        begin
            dur_nxt      = req.wdata[FTS_DUR_LSB +: 3];
            range_nxt    = req.wdata[FTS_RANGE_BIT];
            trig_nxt     = req.wdata[FTS_TRIG_BIT];
            blank_en_nxt = req.wdata[FTS_BLANK_BIT];
        end
        if (wr_power)
        begin
            pgsel_nxt = req.wdata[FTS_PG_BIT];
            ind_nxt   = req.wdata[FTS_IND_LSB +: 4];
            if (!started_r && mode_code == FTS_MODE_OFF)
                lim_nxt = req.wdata[FTS_LIM_BIT];
        end
        if (start)
        begin
            act_nxt  = 1'b1;
            // a start written together with new timer settings uses the new ones
            cnt_nxt  = dur_cycles(range_nxt, dur_nxt);
            tout_nxt = 1'b0;
            start_hold_nxt = sw_start;
        end
        else if (expire)
        begin
            act_nxt  = 1'b0;
            cnt_nxt  = 32'h0;
            tout_nxt = 1'b1;
        end
        else if (level_end || (act_r && !flash_mode))
        begin
            act_nxt = 1'b0;
            cnt_nxt = 32'h0;
        end
        else if (act_r)
            cnt_nxt = cnt_r - 32'h1;
    end

    // read data mux
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (rd_strobe)
        begin
            rdata_nxt[FTS_DUR_LSB +: 3] = dur_r;
            rdata_nxt[FTS_FAIL_BIT]     = fail_r;
            rdata_nxt[FTS_RANGE_BIT]    = tout_r;
            rdata_nxt[FTS_TRIG_BIT]     = trig_r;
            rdata_nxt[FTS_START_BIT]    = act_r;
            rdata_nxt[FTS_BLANK_BIT]    = bevt_r;
        end
        else if (rd_power)
        begin
            rdata_nxt[FTS_PG_BIT]         = power_good;
            rdata_nxt[FTS_TEMP_LSB +: 2]  = shdn_r ? FTS_TEMP_SHDN : die_temp;
            rdata_nxt[FTS_LIM_BIT]        = lim_r;
            rdata_nxt[FTS_IND_LSB +: 4]   = ind_r;
        end
    end

    // registers
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            dur_r <= FTS_DUR_RST;
            range_r <= 1'b0;
            trig_r <= 1'b0;
            blank_en_r <= FTS_BLANK_RST;
            fail_r <= 1'b0;
            tout_r <= 1'b0;
            bevt_r <= 1'b0;
            shdn_r <= 1'b0;
            pgsel_r <= 1'b0;
            lim_r <= 1'b0;
            started_r <= 1'b0;
            ind_r <= FTS_IND_RST;
            act_r <= 1'b0;
            cnt_r <= 32'h0;
            sync_d_r <= 1'b0;
            start_hold_r <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            dur_r <= dur_nxt;
            range_r <= range_nxt;
            trig_r <= trig_nxt;
            blank_en_r <= blank_en_nxt;
            fail_r <= fail_nxt;
            tout_r <= tout_nxt;
            bevt_r <= bevt_nxt;
            shdn_r <= shdn_nxt;
            pgsel_r <= pgsel_nxt;
            lim_r <= lim_nxt;
            started_r <= started_nxt;
            ind_r <= ind_nxt;
            act_r <= act_nxt;
            cnt_r <= cnt_nxt;
            sync_d_r <= flash_sync_pin;
            start_hold_r <= start_hold_nxt;
            rdata <= rdata_nxt;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign gpio_out               = pgsel_r ? gpio_value : power_good;
    assign strobe_active          = act_r;
    assign current_reduced        = act_r && blank_en_r && blank_pin;
    assign indicator_current_code = ind_r;
    // limit selection with high-current blanking exception
    assign valley_limit_ma = (high_current_pin && blank_pin)
                           ? (lim_r ? FTS_LIM_HIHC_MA : FTS_LIM_LOHC_MA)
                           : (lim_r ? FTS_LIM_HI_MA : FTS_LIM_LO_MA);

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_fail_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
        led_fault |=> fail_r)
        else $error("led failure flag not set");
    a_tout_expire: assert property (@(posedge core_clk) disable iff (!rstn)
        expire && !start |=> tout_r && !act_r)
        else $error("expiry did not end strobe");
    a_tout_restart: assert property (@(posedge core_clk) disable iff (!rstn)
        start |=> !tout_r && act_r)
        else $error("restart did not clear timeout");
    a_lim_lock: assert property (@(posedge core_clk) disable iff (!rstn)
        started_r |=> $stable(lim_r))
        else $error("limit bit changed after start");
    a_blank_evt: assert property (@(posedge core_clk) disable iff (!rstn)
        blank_en_r && blank_pin |=> bevt_r)
        else $error("blanking event lost");
    a_rd_start: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_strobe |=> rdata[FTS_START_BIT] == $past(act_r))
        else $error("start bit read wrong");
    a_gpio_route: assert property (@(posedge core_clk) disable iff (!rstn)
        !pgsel_r |-> gpio_out == power_good)
        else $error("gpio routing wrong");
    a_shdn_read: assert property (@(posedge core_clk) disable iff (!rstn)
        shdn_r && rd_power |=> rdata[FTS_TEMP_LSB +: 2] == FTS_TEMP_SHDN)
        else $error("shutdown code not reported");
    a_sw_start: assert property (@(posedge core_clk) disable iff (!rstn)
        sw_start && flash_mode |=> act_r)
        else $error("strobe did not start");
    // read paths, write paths, counter, triggers, limit selection and mode gating
    a_mode_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        !flash_mode |=> !act_r)
        else $error("strobe ran outside flash mode");
    a_level_end: assert property (@(posedge core_clk) disable iff (!rstn)
        act_r && flash_mode && !trig_r && !flash_sync_pin && !start_hold_r && !start |=> !act_r)
        else $error("level strobe did not end");
    a_edge_start: assert property (@(posedge core_clk) disable iff (!rstn)
        flash_mode && trig_r && sync_rise |=> act_r)
        else $error("edge trigger did not start");
    a_cnt_down: assert property (@(posedge core_clk) disable iff (!rstn)
        act_r && flash_mode && !start && !expire && !level_end |=> cnt_r == $past(cnt_r) - 32'h1)
        else $error("safety counter did not step");
    a_range_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_strobe |=> range_r == $past(req.wdata[FTS_RANGE_BIT]))
        else $error("range bit not stored");
    a_tout_read: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_strobe |=> rdata[FTS_RANGE_BIT] == $past(tout_r))
        else $error("timeout bit read wrong");
    a_fail_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_strobe && !led_fault |=> !fail_r)
        else $error("led failure flag not cleared");
    a_blank_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_strobe && !(blank_en_r && blank_pin) |=> !bevt_r)
        else $error("blanking flag not cleared");
    a_shdn_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_power && !thermal_shdn |=> !shdn_r)
        else $error("shutdown flag not cleared");
    a_pg_read: assert property (@(posedge core_clk) disable iff (!rstn)
        rd_power |=> rdata[FTS_PG_BIT] == $past(power_good))
        else $error("power-good bit read wrong");
    a_ind_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_power |=> indicator_current_code == $past(req.wdata[FTS_IND_LSB +: 4]))
        else $error("indicator code not stored");
    a_limit_hc: assert property (@(posedge core_clk) disable iff (!rstn)
        high_current_pin && blank_pin && lim_r |-> valley_limit_ma == FTS_LIM_HIHC_MA)
        else $error("high-current limit wrong");
    a_lim_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_power && !started_r && mode_code == FTS_MODE_OFF |=> lim_r == $past(req.wdata[FTS_LIM_BIT]))
        else $error("limit bit not stored in shutdown");
endmodule
`default_nettype wire

// [fts_host_model.sv]
// host processor model: register writes and reads over the request port
`timescale 1ns/1ps
`default_nettype none
module fts_host_model
    import fts_pkg::*;
(
    input  wire logic       core_clk,
    output var  fts_req_s   req,
    input  wire logic [7:0] rdata
);
    initial req = '0;
    // one-cycle write pulse launched just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req <= '0;
    endtask
    // one-cycle read pulse; data is taken in the cycle after the pulse edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        req <= '0;
        #1 d = rdata;
    endtask
endmodule
`default_nettype wire

// [flash_timer_status_regs_tb.sv]
// testbench: strobe timer, flags and limit selection of the register block
`timescale 1ns/1ps
`default_nettype none
module flash_timer_status_regs_tb;
    import fts_pkg::*;
    localparam longint CLK = 80000000; // slow tick keeps durations short
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] mode_code, die_temp;
    logic flash_sync_pin, blank_pin, high_current_pin, led_fault, power_good, thermal_shdn;
    logic gpio_value, gpio_out, strobe_active, current_reduced;
    logic [7:0] rdata;
    logic [11:0] valley_limit_ma;
    logic [3:0] indicator_current_code;
    fts_req_s req;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #4 core_clk = ~core_clk;
    fts_host_model host (.core_clk(core_clk), .req(req), .rdata(rdata));
    fts_regs #(.CLK_PS(CLK)) u_dut (.core_clk(core_clk), .rstn(rstn), .req(req),
        .rdata(rdata), .mode_code(mode_code), .flash_sync_pin(flash_sync_pin),
        .blank_pin(blank_pin), .high_current_pin(high_current_pin), .led_fault(led_fault),
        .power_good(power_good), .die_temp(die_temp), .thermal_shdn(thermal_shdn),
        .gpio_value(gpio_value), .gpio_out(gpio_out), .strobe_active(strobe_active),
        .current_reduced(current_reduced), .valley_limit_ma(valley_limit_ma),
        .indicator_current_code(indicator_current_code));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] d;
        host.rd(a, d);
        chk("register", {4'h0, e & m}, {4'h0, d & m});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // cycle limit cuts a hang short
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            errors++;
            complete_run();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rchk(FTS_ADDR_STROBE, 8'hc0, 8'hff);
        rchk(FTS_ADDR_POWER, 8'h00, 8'hff);
        rchk(8'h05, 8'h00, 8'hff);
        chk("limit", FTS_LIM_LO_MA, valley_limit_ma);
        @(posedge core_clk) power_good <= 1'b1;
        rchk(FTS_ADDR_POWER, 8'h80, 8'hff);
    endtask
    task automatic t_limit();
        host.wr(FTS_ADDR_POWER, 8'h92);
        rchk(FTS_ADDR_POWER, 8'h92, 8'hff);
        chk("indicator", 12'h2, {8'h0, indicator_current_code});
        chk("limit", FTS_LIM_HI_MA, valley_limit_ma);
        chk("gpio", 12'h0, {11'h0, gpio_out});
        @(posedge core_clk) mode_code <= FTS_MODE_FLASH;
        host.wr(FTS_ADDR_POWER, 8'h01);
        rchk(FTS_ADDR_POWER, 8'h91, 8'hff);
        chk("gpio", 12'h1, {11'h0, gpio_out});
    endtask
    task automatic run_strobe(input logic rng);
        int n;
        longint ex;
        logic [7:0] d;
        ex = (rng ? FTS_DUR1_US10[0] : FTS_DUR0_US10[0]) * 64'd100000000 / CLK;
        host.wr(FTS_ADDR_STROBE, {4'h0, rng, 3'h3});
        rchk(FTS_ADDR_STROBE, 8'h02, 8'h0a);
        n = 2;
        if (!rng)
        begin
            @(posedge core_clk) {blank_pin, high_current_pin} <= 2'h3;
            tick(2);
            chk("reduced", 12'h1, {11'h0, current_reduced});
            chk("limit", FTS_LIM_HIHC_MA, valley_limit_ma);
            @(posedge core_clk) {blank_pin, high_current_pin} <= 2'h0;
            n = 6;
        end
        while (strobe_active === 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        chk("length", 12'h1, {11'h0, (n >= ex - 3 && n <= ex + 3)});
        host.rd(FTS_ADDR_STROBE, d);
        chk("status", {4'h0, 7'h04, ~rng}, {4'h0, d});
    endtask
    task automatic t_trigger();
        host.wr(FTS_ADDR_STROBE, 8'h00);
        @(posedge core_clk) {flash_sync_pin, blank_pin} <= 2'h3;
        tick(3);
        chk("level on", 12'h1, {11'h0, strobe_active});
        chk("no blank", 12'h0, {11'h0, current_reduced});
        @(posedge core_clk) {flash_sync_pin, blank_pin} <= 2'h0;
        tick(3);
        chk("level off", 12'h0, {11'h0, strobe_active});
        host.wr(FTS_ADDR_STROBE, 8'h04);
        @(posedge core_clk) flash_sync_pin <= 1'b1;
        @(posedge core_clk) flash_sync_pin <= 1'b0;
        tick(3);
        chk("edge run", 12'h1, {11'h0, strobe_active});
        while (strobe_active === 1'b1)
            tick(1);
        @(posedge core_clk) mode_code <= 2'h1;
        host.wr(FTS_ADDR_STROBE, 8'h02);
        tick(2);
        chk("refused", 12'h0, {11'h0, strobe_active});
    endtask
    task automatic t_flags();
        @(posedge core_clk) {led_fault, thermal_shdn, die_temp} <= 4'hd;
        @(posedge core_clk) {led_fault, thermal_shdn} <= 2'h0;
        rchk(FTS_ADDR_STROBE, 8'h10, 8'h10);
        rchk(FTS_ADDR_STROBE, 8'h00, 8'h10);
        rchk(FTS_ADDR_POWER, 8'h60, 8'h60);
        rchk(FTS_ADDR_POWER, 8'h20, 8'h60);
    endtask
    initial
    begin
        {mode_code, die_temp, flash_sync_pin, blank_pin, high_current_pin} = '0;
        {led_fault, power_good, thermal_shdn, gpio_value} = '0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_limit();
        run_strobe(1'b0);
        run_strobe(1'b1);
        t_trigger();
        t_flags();
        complete_run();
    end
endmodule
`default_nettype wire
